// [hw/bcmc_pkg.sv]
/*
  bcmc_pkg: register map, field layout, reset values and codes for the
  block cipher mode configuration block.
  Assumes a 32-bit classic wishbone slave with byte addresses.
*/
package bcmc_pkg;
  // register byte offsets
  localparam logic [7:0] BCMC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] BCMC_OFF_MODE   = 8'h04;
  localparam logic [7:0] BCMC_OFF_STAT   = 8'h1c;
  localparam logic [7:0] BCMC_OFF_CTR    = 8'h20;
  localparam logic [7:0] BCMC_OFF_IDATA  = 8'h40;
  localparam logic [7:0] BCMC_OFF_ODATA  = 8'h50;
  localparam int         BCMC_NWORDS     = 4;

  // mode register fields
  localparam int BCMC_XFER_LSB = 8;
  localparam int BCMC_KEY_LSB  = 10;
  localparam int BCMC_CHN_LSB  = 12;
  localparam int BCMC_LAST_BIT = 15;
  localparam int BCMC_SEG_LSB  = 16;
  localparam int BCMC_UNL_LSB  = 20;
  localparam logic [31:0] BCMC_MODE_MASK = 32'h0007ff00;
  localparam logic [31:0] BCMC_MODE_RST  = 32'h00000000;

  // control and status bits
  localparam int BCMC_CTRL_START = 0;
  localparam int BCMC_STAT_FLAG  = 0;
  localparam int BCMC_STAT_UNL   = 1;
  localparam int BCMC_STAT_BUSY  = 2;

  localparam logic [3:0] BCMC_UNLOCK_CODE = 4'he;

  // transfer modes
  localparam logic [1:0] BCMC_XFER_MANUAL = 2'h0;
  localparam logic [1:0] BCMC_XFER_AUTO   = 2'h1;
  localparam logic [1:0] BCMC_XFER_DMA    = 2'h2;

  // key length codes
  localparam logic [1:0] BCMC_KEY_128 = 2'h0;
  localparam logic [1:0] BCMC_KEY_192 = 2'h1;
  localparam logic [1:0] BCMC_KEY_256 = 2'h2;

  // chaining mode codes
  localparam logic [2:0] BCMC_CHN_ECB = 3'h0;
  localparam logic [2:0] BCMC_CHN_CBC = 3'h1;
  localparam logic [2:0] BCMC_CHN_OFB = 3'h2;
  localparam logic [2:0] BCMC_CHN_CFB = 3'h3;
  localparam logic [2:0] BCMC_CHN_CTR = 3'h4;
  localparam logic [2:0] BCMC_CHN_GCM = 3'h5;

  // feedback segment codes
  localparam logic [2:0] BCMC_SEG_128 = 3'h0;
  localparam logic [2:0] BCMC_SEG_64  = 3'h1;
  localparam logic [2:0] BCMC_SEG_32  = 3'h2;
  localparam logic [2:0] BCMC_SEG_16  = 3'h3;
  localparam logic [2:0] BCMC_SEG_8   = 3'h4;

  typedef enum logic [1:0] {
    BCMC_ST_IDLE = 2'b01,
    BCMC_ST_BUSY = 2'b10
  } bcmc_state_e;
endpackage

// [hw/bcmc_top.sv]
/*
  bcmc_top: mode register, unlock guard, data registers, result flag and
  counter step of a block cipher engine, reached over classic wishbone.
  Assumes an external cipher core that takes core_start_o and answers
  with one core_done_i pulse and the result, and a dma path that takes
  one dma_wr_o pulse per result in dma transfer mode.
*/
module bcmc_top
  import bcmc_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [7:0]   adr_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [31:0]  dat_i,
  output logic      [31:0]  dat_o,
  output logic              ack_o,
  output logic              core_start_o,
  output logic      [127:0] core_data_o,
  input  wire logic         core_done_i,
  input  wire logic [127:0] core_result_i,
  output logic      [8:0]   key_bits_o,
  output logic      [2:0]   chaining_mode_o,
  output logic      [7:0]   segment_bits_o,
  output logic      [15:0]  counter_o,
  output logic              result_available_o,
  input  wire logic [31:0]  desc_addr_i,
  output logic              dma_wr_o,
  output logic      [31:0]  dma_addr_o,
  output logic      [127:0] dma_data_o
);
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  bcmc_state_e state;
  bcmc_state_e next_state;
  logic [31:0] mode_cfg;
  logic [31:0] next_mode_cfg;
  logic        unlocked;
  logic        next_unlocked;
  logic [31:0] in_data [BCMC_NWORDS];
  logic [31:0] next_in_data [BCMC_NWORDS];
  logic [31:0] out_data [BCMC_NWORDS];
  logic [31:0] next_out_data [BCMC_NWORDS];
  logic [3:0]  in_written;
  logic [3:0]  next_in_written;
  logic        flag;
  logic        next_flag;
  logic [15:0] ctr;
  logic [15:0] next_ctr;
  logic        ack;
  logic        next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        start;
  logic        next_start;
  logic        dma_wr;
  logic        next_dma_wr;
  logic [31:0] dma_addr;
  logic [31:0] next_dma_addr;
  logic [127:0] dma_data;
  logic [127:0] next_dma_data;

  logic        wr;
  logic        rd;
  logic [31:0] wmask;
  logic [1:0]  xfer;
  logic [1:0]  key_code;
  logic [2:0]  seg_code;
  logic        last_out;
  logic        ctr_mode;
  logic        is_idata;
  logic        is_odata;
  logic [1:0]  widx;
  logic        go;
  logic        done;

  // the access completes at the edge where ack is seen high
  assign wr       = cyc_i & stb_i & ack & we_i;
  assign rd       = cyc_i & stb_i & ack & ~we_i;
  assign wmask    = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                     {8{sel_i[0]}}};
  assign xfer     = mode_cfg[BCMC_XFER_LSB +: 2];
  assign key_code = mode_cfg[BCMC_KEY_LSB +: 2];
  assign seg_code = mode_cfg[BCMC_SEG_LSB +: 3];
  assign last_out = mode_cfg[BCMC_LAST_BIT];
  assign ctr_mode = (chaining_mode_o == BCMC_CHN_CTR);
  assign is_idata = (adr_i[7:4] == BCMC_OFF_IDATA[7:4]);
  assign is_odata = (adr_i[7:4] == BCMC_OFF_ODATA[7:4]);
  assign widx     = adr_i[3:2];
  assign done     = (state == BCMC_ST_BUSY) & core_done_i;

  // auto and dma start once all four input words are loaded
  assign go = (state == BCMC_ST_IDLE) &
              ((xfer != BCMC_XFER_MANUAL && in_written == 4'hf) ||
               (wr && adr_i == BCMC_OFF_CTRL &&
                sel_i[0] && dat_i[BCMC_CTRL_START]));

  always_comb begin
    case (key_code)
      BCMC_KEY_192: key_bits_o = 9'd192;
      BCMC_KEY_256: key_bits_o = 9'd256;
      default:      key_bits_o = 9'd128;
    endcase
  end

  always_comb begin
    case (seg_code)
      BCMC_SEG_64: segment_bits_o = 8'd64;
      BCMC_SEG_32: segment_bits_o = 8'd32;
      BCMC_SEG_16: segment_bits_o = 8'd16;
      BCMC_SEG_8:  segment_bits_o = 8'd8;
      default:     segment_bits_o = 8'd128;
    endcase
  end

  // chaining code passed to the core
  assign chaining_mode_o = mode_cfg[BCMC_CHN_LSB +: 3];

  // counter block low 16 bits carry the step
  always_comb begin
    core_data_o = {in_data[0], in_data[1], in_data[2], in_data[3]};
    if (ctr_mode) begin
      core_data_o[15:0] = in_data[3][15:0] + ctr;
    end
  end

  always_comb begin
    next_state      = state;
    next_mode_cfg   = mode_cfg;
    next_unlocked   = unlocked;
    next_in_data    = in_data;
    next_out_data   = out_data;
    next_in_written = in_written;
    next_flag       = flag;
    next_ctr        = ctr;
    next_ack        = cyc_i & stb_i & ~ack;
    next_rdata      = 32'h00000000;
    next_start      = 1'b0;
    next_dma_wr     = 1'b0;
    next_dma_addr   = dma_addr;
    next_dma_data   = dma_data;

    // read data is prepared with ack
    if (cyc_i && stb_i && !ack && !we_i) begin
      if (is_odata) begin
        next_rdata = out_data[widx];
      end else begin
        case (adr_i)
          BCMC_OFF_MODE: next_rdata = mode_cfg & BCMC_MODE_MASK;
          BCMC_OFF_STAT: begin
            next_rdata[BCMC_STAT_FLAG] = flag;
            next_rdata[BCMC_STAT_UNL]  = unlocked;
            next_rdata[BCMC_STAT_BUSY] = (state == BCMC_ST_BUSY);
          end
          BCMC_OFF_CTR:  next_rdata = {16'h0000, ctr};
          default:       next_rdata = 32'h00000000;
        endcase
      end
    end

    if (wr && adr_i == BCMC_OFF_MODE) begin
      // first write needs the unlock code
      if (unlocked ||
          dat_i[BCMC_UNL_LSB +: 4] == BCMC_UNLOCK_CODE) begin
        next_mode_cfg = ((mode_cfg & ~wmask) | (dat_i & wmask)) &
                        BCMC_MODE_MASK;
        next_unlocked = 1'b1;
        next_ctr      = 16'h0000;
      end
    end

    if (rd && is_odata && !last_out && xfer != BCMC_XFER_DMA) begin
      next_flag = 1'b0;
    end

    if (wr && is_idata) begin
      next_in_data[widx] = (in_data[widx] & ~wmask) | (dat_i & wmask);
      next_in_written[widx] = 1'b1;
      if (last_out) begin
        next_flag = 1'b0;
      end
    end

    case (state)
      BCMC_ST_IDLE: begin
        if (go) begin
          next_start      = 1'b1;
          next_in_written = 4'h0;
          next_state      = BCMC_ST_BUSY;
          if (xfer == BCMC_XFER_DMA && !last_out) begin
            next_flag = 1'b0;
          end
        end
      end
      BCMC_ST_BUSY: begin
        if (core_done_i) begin
          next_state = BCMC_ST_IDLE;
          for (int i = 0; i < BCMC_NWORDS; i++) begin
            next_out_data[i] = core_result_i[127 - 32*i -: 32];
          end
          // result flag set wins over any clear
          next_flag = 1'b1;
          // dma mode writes to descriptor address
          if (xfer == BCMC_XFER_DMA) begin
            next_dma_wr   = 1'b1;
            next_dma_addr = desc_addr_i;
            next_dma_data = core_result_i;
          end
          if (ctr_mode) begin
            next_ctr = ctr + 16'h0001;
          end
        end
      end
      default: next_state = BCMC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= BCMC_ST_IDLE;
      mode_cfg   <= BCMC_MODE_RST;
      unlocked   <= 1'b0;
      in_data    <= '{default: 32'h00000000};
      out_data   <= '{default: 32'h00000000};
      in_written <= 4'h0;
      flag       <= 1'b0;
      ctr        <= 16'h0000;
      ack        <= 1'b0;
      rdata      <= 32'h00000000;
      start      <= 1'b0;
      dma_wr     <= 1'b0;
      dma_addr   <= 32'h00000000;
      dma_data   <= 128'h0;
    end else if (ce_i) begin
      state      <= next_state;
      mode_cfg   <= next_mode_cfg;
      unlocked   <= next_unlocked;
      in_data    <= next_in_data;
      out_data   <= next_out_data;
      in_written <= next_in_written;
      flag       <= next_flag;
      ctr        <= next_ctr;
      ack        <= next_ack;
      rdata      <= next_rdata;
      start      <= next_start;
      dma_wr     <= next_dma_wr;
      dma_addr   <= next_dma_addr;
      dma_data   <= next_dma_data;
    end
  end

  assign dat_o              = rdata;
  assign ack_o              = ack;
  assign core_start_o       = start;
  assign counter_o          = ctr;
  assign result_available_o = flag;
  assign dma_wr_o           = dma_wr;
  assign dma_addr_o         = dma_addr;
  assign dma_data_o         = dma_data;

  sequence s_block_done;
    ce_i && done;
  endsequence
  sequence s_mode_write;
    ce_i && wr && adr_i == BCMC_OFF_MODE;
  endsequence

  AST_KEY_DECODE: assert property (
    (key_code == BCMC_KEY_192 |-> key_bits_o == 9'd192) and
    (key_code == BCMC_KEY_256 |-> key_bits_o == 9'd256) and
    (key_code == BCMC_KEY_128 |-> key_bits_o == 9'd128))
    else $error("key length decode wrong");

  AST_MODE_TAKEN: assert property (
    s_mode_write and (unlocked && sel_i[1])
    |=> chaining_mode_o == $past(dat_i[BCMC_CHN_LSB +: 3]))
    else $error("chaining mode not taken");

  AST_CTR_STEP: assert property (
    s_block_done and ctr_mode |=> ctr == $past(ctr) + 16'h0001)
    else $error("counter did not step");

  AST_RESULT_LOAD: assert property (
    s_block_done |=> flag && out_data[0] == $past(core_result_i[127:96])
    && state == BCMC_ST_IDLE)
    else $error("result not presented");

  AST_DMA_WRITE: assert property (
    s_block_done and xfer == BCMC_XFER_DMA
    |=> dma_wr_o && dma_addr_o == $past(desc_addr_i) ##1 !dma_wr_o)
    else $error("dma write missing");

  AST_FLAG_READ_CLR: assert property (
    ce_i && rd && is_odata && !last_out && xfer != BCMC_XFER_DMA && !done
    |=> !flag)
    else $error("flag not cleared by read");

  AST_FLAG_WRITE_CLR: assert property (
    ce_i && wr && is_idata && last_out && !done |=> !flag)
    else $error("flag not cleared by write");

  AST_SEG_DECODE: assert property (
    (seg_code == BCMC_SEG_8 |-> segment_bits_o == 8'd8) and
    (seg_code == BCMC_SEG_64 |-> segment_bits_o == 8'd64) and
    (seg_code == BCMC_SEG_128 |-> segment_bits_o == 8'd128))
    else $error("segment decode wrong");

  AST_UNLOCK_READ: assert property (
    ack_o && adr_i == BCMC_OFF_MODE |-> dat_o[BCMC_UNL_LSB +: 4] == 4'h0)
    else $error("unlock field not zero");

  AST_LOCKED_IGNORE: assert property (
    s_mode_write and (!unlocked &&
    dat_i[BCMC_UNL_LSB +: 4] != BCMC_UNLOCK_CODE)
    |=> $stable(mode_cfg) && !unlocked)
    else $error("locked mode register changed");
endmodule

// [test/bcmc_core_model.sv]
/*
  bcmc_core_model: behavioural cipher core for the bench.
  Assumes one start pulse per block; answers lag_i + 1 cycles later with one
  done pulse, result = data xor MASK; result toggles when not valid.
*/
module bcmc_core_model
  import bcmc_pkg::*;
#(
  parameter logic [127:0] MASK = 128'h0
)(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         start_i,
  input  wire logic [127:0] data_i,
  input  wire logic [3:0]   lag_i,
  output logic              done_o,
  output logic      [127:0] result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [127:0] held;
  logic [3:0]   cnt;
  logic         busy;
  always_ff @(posedge clk_i) begin
    done_o   <= 1'b0;
    result_o <= ~result_o;
    if (rst_i) begin
      busy     <= 1'b0;
      cnt      <= 4'h0;
      held     <= '0;
      result_o <= '0;
    end else if (start_i && !busy) begin
      busy <= 1'b1;
      cnt  <= lag_i;
      held <= data_i ^ MASK;
    end else if (busy && cnt == 4'h0) begin
      busy     <= 1'b0;
      done_o   <= 1'b1;
      result_o <= held;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

// [test/testbench.sv]
/*
  testbench: wishbone driven checks of the cipher mode block.
  Assumes bcmc_top with one cycle ack and the core model on its far side.
*/
module testbench
  import bcmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] MSK = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  localparam logic [127:0] D   = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] DX  = D ^ MSK;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc_i = 1'b0;
  logic         stb_i = 1'b0;
  logic         we_i = 1'b0;
  logic [7:0]   adr_i = 8'h00;
  logic [31:0]  dat_i = 32'h0;
  logic [31:0]  desc_addr_i = 32'h0;
  logic [3:0]   lag = 4'h0;
  logic [31:0]  dat_o;
  logic [31:0]  dma_addr_o;
  logic [31:0]  q;
  logic [127:0] core_data_o;
  logic [127:0] core_result_i;
  logic [127:0] dma_data_o;
  logic         ack_o;
  logic         core_start_o;
  logic         core_done_i;
  logic         flag;
  logic         dma_wr_o;
  logic [8:0]   key_bits_o;
  logic [2:0]   chaining_mode_o;
  logic [7:0]   segment_bits_o;
  logic [15:0]  counter_o;
  int           bad_count = 0;
  int           n_checks = 0;
  int           cycles = 0;

  bcmc_top uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .core_start_o(core_start_o),
    .core_data_o(core_data_o), .core_done_i(core_done_i),
    .core_result_i(core_result_i), .key_bits_o(key_bits_o),
    .chaining_mode_o(chaining_mode_o), .segment_bits_o(segment_bits_o),
    .counter_o(counter_o), .result_available_o(flag),
    .desc_addr_i(desc_addr_i), .dma_wr_o(dma_wr_o),
    .dma_addr_o(dma_addr_o), .dma_data_o(dma_data_o));
  bcmc_core_model #(.MASK(MSK)) core (.clk_i(clk_i), .rst_i(rst_i),
    .start_i(core_start_o), .data_i(core_data_o), .lag_i(lag),
    .done_o(core_done_i), .result_o(core_result_i));

  initial forever #5 clk_i = ~clk_i;

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle, read data left in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  function automatic logic [31:0] mw(logic [1:0] x, logic [1:0] k,
                                     logic [2:0] c, logic l, logic [2:0] s);
    return {13'h0, s, l, c, k, x, 8'h00};
  endfunction

  task automatic put4(input logic [127:0] d);
    for (int i = 0; i < 4; i++)
      wb(1'b1, BCMC_OFF_IDATA + 8'(4 * i), d[127 - 32 * i -: 32]);
  endtask

  task automatic wflag();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic t_reset();
    rd(BCMC_OFF_MODE, 32'h0);
    chk(key_bits_o, 128);
    chk(segment_bits_o, 128);
    rd(8'h80, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_lock();
    wb(1'b1, BCMC_OFF_MODE, mw(1, 2, 3, 0, 1) | 32'h00500000);
    rd(BCMC_OFF_MODE, 32'h0);
    rd(BCMC_OFF_STAT, 32'h0);
    wb(1'b1, BCMC_OFF_MODE, mw(1, 2, 3, 1, 1) | 32'h00e00000);
    rd(BCMC_OFF_MODE, mw(1, 2, 3, 1, 1));
    rd(BCMC_OFF_STAT, 32'h2);
    wb(1'b1, BCMC_OFF_MODE, mw(0, 1, 2, 0, 4) | 32'h00300000);
    rd(BCMC_OFF_MODE, mw(0, 1, 2, 0, 4));
    $display("test lock done");
  endtask

  task automatic t_codes();
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, BCMC_OFF_MODE, mw(0, 2'(k), 0, 0, 0));
      @(posedge clk_i);
      chk(key_bits_o, 128 + 64 * k);
    end
    for (int c = 0; c < 6; c++) begin
      wb(1'b1, BCMC_OFF_MODE, mw(0, 0, 3'(c), 0, 0));
      @(posedge clk_i);
      chk(chaining_mode_o, c);
    end
    for (int s = 0; s < 5; s++) begin
      wb(1'b1, BCMC_OFF_MODE, mw(0, 0, BCMC_CHN_CFB, 0, 3'(s)));
      @(posedge clk_i);
      chk(segment_bits_o, 128 >> s);
    end
    $display("test codes done");
  endtask

  task automatic t_manual();
    lag <= 4'h9;
    wb(1'b1, BCMC_OFF_MODE, mw(BCMC_XFER_MANUAL, 0, BCMC_CHN_ECB, 0, 0));
    put4(D);
    wb(1'b1, BCMC_OFF_CTRL, 32'h1);
    wflag();
    chk(flag, 1'b1);
    rd(BCMC_OFF_ODATA, D[127:96] ^ MSK[127:96]);
    @(posedge clk_i);
    chk(flag, 1'b0);
    for (int i = 1; i < 4; i++)
      rd(BCMC_OFF_ODATA + 8'(4 * i), DX[127 - 32 * i -: 32]);
    $display("test manual done");
  endtask

  task automatic t_lod();
    lag <= 4'h0;
    wb(1'b1, BCMC_OFF_MODE, mw(BCMC_XFER_AUTO, 0, BCMC_CHN_CBC, 1, 0));
    put4(D);
    wflag();
    chk(flag, 1'b1);
    wb(1'b1, BCMC_OFF_IDATA, ~D[127:96]);
    @(posedge clk_i);
    chk(flag, 1'b0);
    for (int i = 1; i < 4; i++)
      wb(1'b1, BCMC_OFF_IDATA + 8'(4 * i), ~D[127 - 32 * i -: 32]);
    wflag();
    chk(flag, 1'b1);
    rd(BCMC_OFF_ODATA, ~D[127:96] ^ MSK[127:96]);
    $display("test last output done");
  endtask

  task automatic t_ctr();
    logic [31:0] e3;
    e3 = {D[31:16], D[15:0] + 16'h1} ^ MSK[31:0];
    wb(1'b1, BCMC_OFF_MODE, mw(BCMC_XFER_AUTO, 0, BCMC_CHN_CTR, 0, 0));
    rd(BCMC_OFF_ODATA, ~D[127:96] ^ MSK[127:96]);
    @(posedge clk_i);
    chk(counter_o, 16'h0);
    chk(flag, 1'b0);
    put4(D);
    wflag();
    chk(counter_o, 16'h1);
    rd(BCMC_OFF_ODATA, D[127:96] ^ MSK[127:96]);
    put4(D);
    wflag();
    chk(counter_o, 16'h2);
    rd(BCMC_OFF_ODATA + 8'hc, e3);
    $display("test counter done");
  endtask

  task automatic t_dma();
    int n;
    n = 0;
    lag <= 4'h3;
    desc_addr_i <= 32'h00002340;
    wb(1'b1, BCMC_OFF_MODE, mw(BCMC_XFER_DMA, 0, BCMC_CHN_ECB, 0, 0));
    // no output reads while dma runs
    put4(D);
    do begin
      @(posedge clk_i);
      n++;
    end while (dma_wr_o !== 1'b1 && n < 100);
    chk(dma_wr_o, 1'b1);
    chk(dma_addr_o, 32'h00002340);
    chk(dma_data_o, D ^ MSK);
    $display("test dma done");
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_lock();
    t_codes();
    t_manual();
    t_lod();
    t_ctr();
    t_dma();
    close_out();
  end
endmodule
